// File: idxo_regs.svh
// constants for the indexed literal offset executor
// assumes the including file wants plain macros, no types
`ifndef IDXO_REGS_SVH
`define IDXO_REGS_SVH

// ----------------------------------------
// opcode fields
// ----------------------------------------
`define IDXO_OP_ADD      6'h09
`define IDXO_OP_BITONE   4'h8
`define IDXO_OP_ONES     7'h34
`define IDXO_ADD_HI      15
`define IDXO_ADD_LO      10
`define IDXO_BITONE_HI   15
`define IDXO_BITONE_LO   12
`define IDXO_ONES_HI     15
`define IDXO_ONES_LO     9
`define IDXO_DEST_BIT    9
`define IDXO_ACC_BIT     8
`define IDXO_BITN_HI     11
`define IDXO_BITN_LO     9
`define IDXO_FILE_HI     7
`define IDXO_FILE_LO     0

// ----------------------------------------
// addressing and values
// ----------------------------------------
`define IDXO_INDEX_MAX   8'h5F
`define IDXO_ACC_LO_PAGE 4'h0
`define IDXO_ACC_HI_PAGE 4'hF
`define IDXO_DEST_W      1'b0
`define IDXO_FILL_VALUE  8'hFF
`define IDXO_W_RESET     8'h00
`define IDXO_ADDR_RESET  12'h000
`define IDXO_WORD_RESET  16'h0000
`define IDXO_BYTE_ZERO   8'h00
`define IDXO_NIB_TOP     3

`endif

// File: idxo_pkg.sv
// types shared by the indexed literal offset executor
// assumes idxo_regs.svh for numeric constants
package idxo_pkg;

  typedef struct packed {
    logic n;
    logic overflow_flag;
    logic z;
    logic digit_carry_flag;
    logic c;
  } idxo_status_t;

  typedef enum logic [3:0] {
    IDXO_OP_NONE = 4'h1,
    IDXO_OP_ADDW = 4'h2,
    IDXO_OP_BSET = 4'h4,
    IDXO_OP_FILL = 4'h8
  } idxo_op_t;

  typedef struct packed {
    idxo_op_t    op;
    logic        dest_mem;
    logic [2:0]  bit_sel;
    logic        indexed;
    logic [11:0] addr;
  } idxo_decode_t;

  typedef enum logic [4:0] {
    IDXO_ST_IDLE    = 5'h01,
    IDXO_ST_DECODE  = 5'h02,
    IDXO_ST_READ    = 5'h04,
    IDXO_ST_PROCESS = 5'h08,
    IDXO_ST_WRITE   = 5'h10
  } idxo_state_t;

endpackage

// File: idxo_data_ram.sv
// byte-wide data memory for the executor
// assumes one clock; read data is registered, no reset on contents
`timescale 1ns/100ps
`default_nettype none

module idxo_data_ram #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // clock
  input  wire logic          mclk_i,
  // access port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem_reg [0:(1<<AW)-1];

  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem_reg[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    rdata_o <= mem_reg[addr_i];
  end

endmodule

`default_nettype wire

// File: idxo_exec.sv
// four-phase executor for add-to-W, bit set and set-all with indexed literal offset addressing
// assumes instruction source on mclk_i; extended-set enable arrives as a static pin
`timescale 1ns/100ps
`default_nettype none
`include "idxo_regs.svh"

module idxo_exec #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  // configuration pin
  input  wire logic                  extended_set_enable_i,
  // instruction issue
  input  wire logic                  instr_valid_i,
  input  wire logic [15:0]           instr_word_i,
  input  wire logic [AW-1:0]         software_stack_pointer_i,
  input  wire logic [3:0]            bank_select_pointer_i,
  // working register load, idle only
  input  wire logic                  w_load_i,
  input  wire logic [DW-1:0]         w_load_data_i,
  // memory side port, idle only
  input  wire logic                  dbg_we_i,
  input  wire logic [AW-1:0]         dbg_addr_i,
  input  wire logic [DW-1:0]         dbg_wdata_i,
  output logic      [DW-1:0]         dbg_rdata_o,
  // results
  output logic                       ready_o,
  output logic                       done_o,
  output logic                       unsupported_o,
  output logic                       indexed_o,
  output logic      [AW-1:0]         eff_addr_o,
  output logic      [DW-1:0]         w_o,
  output idxo_pkg::idxo_status_t     status_o,
  output logic                       ext_enabled_o
);
  import idxo_pkg::*;

  // ----------------------------------------
  // enable pin synchroniser
  // ----------------------------------------
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic ext_en_reg;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= extended_set_enable_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ext_en_reg <= 1'b0;
    end else if (sync2_reg == sync3_reg) begin
      ext_en_reg <= sync3_reg;
    end
  end

  // ----------------------------------------
  // phase sequencer
  // ----------------------------------------
  idxo_state_t state_reg;
  idxo_state_t state_next;
  logic        take;

  assign take = instr_valid_i && (state_reg == IDXO_ST_IDLE);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      IDXO_ST_IDLE:    if (take) state_next = IDXO_ST_DECODE;
      IDXO_ST_DECODE:  state_next = IDXO_ST_READ;
      IDXO_ST_READ:    state_next = IDXO_ST_PROCESS;
      IDXO_ST_PROCESS: state_next = IDXO_ST_WRITE;
      IDXO_ST_WRITE:   state_next = IDXO_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg <= IDXO_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // instruction capture and decode
  // ----------------------------------------
  logic [15:0]   word_reg;
  logic [AW-1:0] sp_reg;
  logic [3:0]    bank_reg;
  logic          ext_lat_reg;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      word_reg    <= `IDXO_WORD_RESET;
      sp_reg      <= `IDXO_ADDR_RESET;
      bank_reg    <= `IDXO_ACC_LO_PAGE;
      ext_lat_reg <= 1'b0;
    end else if (take) begin
      word_reg    <= instr_word_i;
      sp_reg      <= software_stack_pointer_i;
      bank_reg    <= bank_select_pointer_i;
      ext_lat_reg <= ext_en_reg;
    end
  end

  idxo_decode_t dec_next;
  idxo_decode_t dec_reg;
  logic [7:0]   file_f;
  logic         acc_bit;

  assign file_f  = word_reg[`IDXO_FILE_HI:`IDXO_FILE_LO];
  assign acc_bit = word_reg[`IDXO_ACC_BIT];

  always_comb begin
    dec_next          = '0;
    dec_next.op       = IDXO_OP_NONE;
    dec_next.dest_mem = word_reg[`IDXO_DEST_BIT];
    dec_next.bit_sel  = word_reg[`IDXO_BITN_HI:`IDXO_BITN_LO];
    if (word_reg[`IDXO_ADD_HI:`IDXO_ADD_LO] == `IDXO_OP_ADD) begin
      dec_next.op = IDXO_OP_ADDW;
    end else if (word_reg[`IDXO_ONES_HI:`IDXO_ONES_LO] == `IDXO_OP_ONES) begin
      dec_next.op       = IDXO_OP_FILL;
      dec_next.dest_mem = 1'b1;
    end else if (word_reg[`IDXO_BITONE_HI:`IDXO_BITONE_LO] == `IDXO_OP_BITONE) begin
      dec_next.op       = IDXO_OP_BSET;
      dec_next.dest_mem = 1'b1;
    end
    if (ext_lat_reg && !acc_bit && (file_f <= `IDXO_INDEX_MAX)) begin
      dec_next.indexed = 1'b1;
      // pointer plus zero-extended offset, wraps in 4 KB
      // offset k is 0 to 95
      dec_next.addr = AW'(sp_reg + {{(AW-8){1'b0}}, file_f});
    // bank select pointer when a is set
    end else if (acc_bit) begin
      dec_next.addr = {bank_reg, file_f};
    end else if (file_f <= `IDXO_INDEX_MAX) begin
      dec_next.addr = {`IDXO_ACC_LO_PAGE, file_f};
    end else begin
      dec_next.addr = {`IDXO_ACC_HI_PAGE, file_f};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      dec_reg <= '0;
    end else if (state_reg == IDXO_ST_DECODE) begin
      dec_reg <= dec_next;
    end
  end

  // ----------------------------------------
  // data memory and process phase
  // ----------------------------------------
  logic          ram_we;
  logic [AW-1:0] ram_addr;
  logic [DW-1:0] ram_wdata;
  logic [DW-1:0] ram_rdata;
  logic [DW-1:0] result_reg;
  logic [DW:0]   sum;
  logic [4:0]    low_sum;
  idxo_status_t  flags_reg;
  idxo_status_t  flags_next;

  // engine owns the port outside idle; side port only when idle
  assign ram_we    = (state_reg == IDXO_ST_WRITE) ? (dec_reg.dest_mem && (dec_reg.op != IDXO_OP_NONE))
                                                  : ((state_reg == IDXO_ST_IDLE) && dbg_we_i);
  assign ram_addr  = (state_reg == IDXO_ST_IDLE) ? dbg_addr_i : dec_reg.addr;
  assign ram_wdata = (state_reg == IDXO_ST_IDLE) ? dbg_wdata_i : result_reg;

  idxo_data_ram #(.AW(AW), .DW(DW)) u_ram (
    .mclk_i  (mclk_i),
    .we_i    (ram_we),
    .addr_i  (ram_addr),
    .wdata_i (ram_wdata),
    .rdata_o (ram_rdata)
  );

  assign sum     = {1'b0, w_o} + {1'b0, ram_rdata};
  assign low_sum = {1'b0, w_o[`IDXO_NIB_TOP:0]} + {1'b0, ram_rdata[`IDXO_NIB_TOP:0]};

  always_comb begin
    flags_next = flags_reg;
    if (dec_reg.op == IDXO_OP_ADDW) begin
      flags_next.c  = sum[DW];
      flags_next.digit_carry_flag = low_sum[`IDXO_NIB_TOP+1];
      flags_next.z  = (sum[DW-1:0] == `IDXO_BYTE_ZERO);
      flags_next.n  = sum[DW-1];
      flags_next.overflow_flag = (w_o[DW-1] == ram_rdata[DW-1]) && (sum[DW-1] != w_o[DW-1]);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      result_reg <= `IDXO_BYTE_ZERO;
      flags_reg  <= '0;
    end else if (state_reg == IDXO_ST_PROCESS) begin
      unique case (dec_reg.op)
        IDXO_OP_ADDW: result_reg <= sum[DW-1:0];
        IDXO_OP_BSET: result_reg <= ram_rdata | (DW'(1) << dec_reg.bit_sel);
        IDXO_OP_FILL: result_reg <= `IDXO_FILL_VALUE;
        IDXO_OP_NONE: result_reg <= ram_rdata;
      endcase
      flags_reg <= flags_next;
    end
  end

  // ----------------------------------------
  // write phase and outputs
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      w_o <= `IDXO_W_RESET;
    end else if ((state_reg == IDXO_ST_IDLE) && w_load_i) begin
      w_o <= w_load_data_i;
    end else if ((state_reg == IDXO_ST_WRITE) && (dec_reg.op == IDXO_OP_ADDW) &&
                 (dec_reg.dest_mem == `IDXO_DEST_W)) begin
      w_o <= result_reg;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      status_o      <= '0;
      done_o        <= 1'b0;
      unsupported_o <= 1'b0;
      indexed_o     <= 1'b0;
      eff_addr_o    <= `IDXO_ADDR_RESET;
      ready_o       <= 1'b1;
      ext_enabled_o <= 1'b0;
    end else begin
      done_o        <= (state_reg == IDXO_ST_WRITE);
      ready_o       <= (state_next == IDXO_ST_IDLE);
      ext_enabled_o <= ext_en_reg;
      if (state_reg == IDXO_ST_WRITE) begin
        status_o      <= flags_reg;
        unsupported_o <= (dec_reg.op == IDXO_OP_NONE);
        indexed_o     <= dec_reg.indexed;
        eff_addr_o    <= dec_reg.addr;
      end
    end
  end

  // side-port read data is the memory's own output register
  assign dbg_rdata_o = ram_rdata;

endmodule

`default_nettype wire

// File: idxo_exec_asserts.sv
// port checker for the indexed literal offset executor
// assumes one clock domain and a bind onto idxo_exec
`timescale 1ns/100ps
`default_nettype none
module idxo_exec_asserts #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // --------------------
  // observed ports
  // --------------------
  input wire logic                   mclk_i,
  input wire logic                   rst_i,
  input wire logic                   instr_valid_i,
  input wire logic [15:0]            instr_word_i,
  input wire logic [AW-1:0]          software_stack_pointer_i,
  input wire logic [3:0]             bank_select_pointer_i,
  input wire logic                   ready_o,
  input wire logic                   done_o,
  input wire logic                   indexed_o,
  input wire logic [AW-1:0]          eff_addr_o,
  input wire logic [DW-1:0]          w_o,
  input wire idxo_pkg::idxo_status_t status_o,
  input wire logic                   ext_enabled_o
);
  import idxo_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic          take;
  logic          low_f;
  logic          op_ok;
  logic          keep_op;
  logic [AW-1:0] idx_sum;
  logic [AW-1:0] bank_addr;
  logic [AW-1:0] high_addr;
  assign bank_addr = {bank_select_pointer_i, instr_word_i[7:0]};
  assign high_addr = {4'hF, instr_word_i[7:0]};
  assign take = instr_valid_i && ready_o;
  assign low_f = instr_word_i[7:0] <= 8'h5F;
  assign keep_op = instr_word_i[15:12] == 4'h8 || instr_word_i[15:9] == 7'h34;
  assign op_ok = keep_op || instr_word_i[15:10] == 6'h09;
  assign idx_sum = software_stack_pointer_i + {4'h0, instr_word_i[7:0]};
  sequence busy_s;
    !ready_o [*4];
  endsequence
  sequence finish_s;
    done_o && ready_o;
  endsequence
  take_done_a: assert property (take |=> busy_s ##1 finish_s)
    else $error("instruction did not finish after four phases");
  done_pulse_a: assert property (done_o |=> !done_o)
    else $error("done held longer than one cycle");
  flags_kept_a: assert property (take && keep_op |-> ##5 status_o == $past(status_o, 4))
    else $error("flags changed by bit set or fill");
  // indexed address; enable output one cycle on shows what the take latched
  idx_addr_a: assert property (take && op_ok && !instr_word_i[8] && low_f ##1 ext_enabled_o
    |-> ##4 indexed_o && eff_addr_o == $past(idx_sum, 5)) else $error("indexed address wrong");
  ext_off_a: assert property (take && op_ok ##1 !ext_enabled_o |-> ##4 !indexed_o)
    else $error("indexed while extension off");
  bank_sel_a: assert property (take && op_ok && instr_word_i[8]
    |-> ##5 eff_addr_o == $past(bank_addr, 5)) else $error("bank address wrong");
  above_5f_a: assert property (take && op_ok && !instr_word_i[8] && !low_f
    |-> ##5 !indexed_o && eff_addr_o == $past(high_addr, 5)) else $error("high page wrong");
  w_keep_a: assert property (take && instr_word_i[15:9] == 7'h13 |-> ##5 w_o == $past(w_o, 4))
    else $error("W changed by memory destination add");
endmodule
bind idxo_exec idxo_exec_asserts #(.AW(AW), .DW(DW)) u_chk (.mclk_i, .rst_i, .instr_valid_i, .instr_word_i,
  .software_stack_pointer_i, .bank_select_pointer_i, .ready_o, .done_o, .indexed_o, .eff_addr_o, .w_o,
  .status_o, .ext_enabled_o);
`default_nettype wire

// File: idxo_tb.sv
// self-checking bench for idxo_exec
// assumes idxo_pkg and idxo_regs.svh compiled first
`timescale 1ns/100ps
`default_nettype none
`include "idxo_regs.svh"
module testbench;
  import idxo_pkg::*;
  logic         mclk_i = 0, rst_i = 1, ext_i = 1, valid = 0, w_load = 0, we = 0;
  logic [15:0]  word = 0;
  logic [11:0]  sp = 0, daddr = 0, eff;
  logic [3:0]   bank = 0;
  logic [7:0]   wdat = 0, ddat = 0, rdata, w_o, exp_w = 0;
  logic         ready, done, unsup, idx, ext_en;
  logic [31:0]  r;
  idxo_status_t st, exp_st = '0;
  int           seed = 29, miscompares = 0, n_tests = 0, cycles = 0;
  initial forever #25 mclk_i = ~mclk_i;
  idxo_exec uut (.mclk_i(mclk_i), .rst_i(rst_i), .extended_set_enable_i(ext_i), .instr_valid_i(valid),
    .instr_word_i(word), .software_stack_pointer_i(sp), .bank_select_pointer_i(bank), .w_load_i(w_load),
    .w_load_data_i(wdat), .dbg_we_i(we), .dbg_addr_i(daddr), .dbg_wdata_i(ddat), .dbg_rdata_o(rdata),
    .ready_o(ready), .done_o(done), .unsupported_o(unsup), .indexed_o(idx), .eff_addr_o(eff), .w_o(w_o),
    .status_o(st), .ext_enabled_o(ext_en));
  task automatic results;
    $display("tests=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      results();
    end
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [11:0] ea(input logic [15:0] wd);
    if (wd[8])
      return {bank, wd[7:0]};
    if (wd[7:0] > 8'h5F)
      return {4'hF, wd[7:0]};
    return ext_i ? sp + {4'h0, wd[7:0]} : {4'h0, wd[7:0]};
  endfunction
  task automatic poke(input logic [11:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    daddr = a;
    ddat = d;
    we = 1;
    @(negedge mclk_i);
    we = 0;
  endtask
  task automatic exec(input logic [15:0] wd);
    int n;
    @(negedge mclk_i);
    word = wd;
    valid = 1;
    @(negedge mclk_i);
    valid = 0;
    n = 0;
    while (done !== 1'b1 && n < 10) begin
      @(negedge mclk_i);
      n++;
    end
    chk(n, 4);
  endtask
  task automatic run(input logic [15:0] wd, input logic [7:0] m, input logic [7:0] wv);
    logic [11:0] a;
    logic [8:0]  s;
    logic [7:0]  e;
    a = ea(wd);
    s = {1'b0, wv} + {1'b0, m};
    e = m;
    exp_w = wv;
    poke(a, m);
    @(negedge mclk_i);
    wdat = wv;
    w_load = 1;
    @(negedge mclk_i);
    w_load = 0;
    exec(wd);
    if (wd[15:10] == `IDXO_OP_ADD) begin
      exp_st = {s[7], wv[7] == m[7] && s[7] != wv[7], s[7:0] == 0, {1'b0, wv[3:0]} + m[3:0] > 5'hF, s[8]};
      if (wd[9])
        e = s[7:0];
      else
        exp_w = s[7:0];
    end else if (wd[15:12] == `IDXO_OP_BITONE)
      e = m | (8'h01 << wd[11:9]);
    else
      e = `IDXO_FILL_VALUE;
    chk(eff, a);
    chk(idx, ext_i && !wd[8] && wd[7:0] <= 8'h5F);
    chk(w_o, exp_w);
    chk(st, exp_st);
    chk(unsup, 0);
    @(negedge mclk_i);
    daddr = a;
    @(negedge mclk_i);
    chk(rdata, e);
  endtask
  initial begin
    repeat (4) @(negedge mclk_i);
    rst_i = 0;
    // the enable pin needs five edges through the filter before its output shows it
    repeat (6) @(negedge mclk_i);
    chk(ready, 1);
    chk(ext_en, 1);
    sp = 12'hA00;
    bank = 4'h3;
    run({`IDXO_OP_ONES, 1'b0, 8'h00}, 8'h00, 8'h00);
    run({`IDXO_OP_ONES, 1'b0, 8'h5F}, 8'h12, 8'h00);
    run({`IDXO_OP_ONES, 1'b0, 8'h60}, 8'h34, 8'h00);
    run({`IDXO_OP_ONES, 1'b1, 8'h2C}, 8'h56, 8'h00);
    run({`IDXO_OP_ADD, 1'b0, 1'b0, 8'h2C}, 8'h20, 8'h17);
    run({`IDXO_OP_BITONE, 3'h7, 1'b0, 8'h0A}, 8'h55, 8'h00);
    run({`IDXO_OP_ADD, 1'b1, 1'b0, 8'h01}, 8'h01, 8'h7F);
    run({`IDXO_OP_ADD, 1'b1, 1'b0, 8'h02}, 8'hFF, 8'h01);
    $display("test corners done");
    for (int i = 0; i < 60; i++) begin
      if (i % 20 == 0) begin
        ext_i = i != 20;
        repeat (6) @(negedge mclk_i);
        chk(ext_en, ext_i);
      end
      r = $random(seed);
      sp = r[31:20];
      bank = r[19:16];
      if (r[8])
        r[7:0] = r[7:0] % 8'h60;
      word = r[10] ? (r[9] ? {`IDXO_OP_ONES, r[12] & r[14], r[7:0]}
        : {`IDXO_OP_BITONE, r[13:11], r[12] & r[14], r[7:0]}) : {`IDXO_OP_ADD, r[11], r[12] & r[14], r[7:0]};
      run(word, r[23:16], r[15:8]);
    end
    $display("test random done");
    exec(16'h0000);
    chk(unsup, 1);
    chk(w_o, exp_w);
    chk(st, exp_st);
    $display("test unsupported done");
    results();
  end
endmodule
`default_nettype wire
